// >>> rtl/adc_regs.sv
`timescale 1ns/1ns
`default_nettype none
module adc_regs #(
  parameter int STARTUP = adc_regs_pkg::STARTUP_CYCLES,
  parameter logic [2:0] VERSION = 3'h1 // arbitrary value
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // serial port pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // converter side
  input wire logic [23:0] current_in,
  input wire logic [23:0] volt_one_in,
  input wire logic [23:0] volt_two_in,
  input wire logic sample_strobe,
  input wire logic [7:0] temp_offset_in,
  output adc_regs_pkg::setup_out_t setup_out,
  output logic [7:0] emission_out,
  output logic busy
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a change counts once stages two and three agree
  logic [2:0] pin_raw;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] pin_stable;
  adc_regs_pkg::serial_pins_t pins;
  assign pin_raw = {sclk, cs_n, mosi};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          sync1[gi] <= (gi != 0);
          sync2[gi] <= (gi != 0);
          sync3[gi] <= (gi != 0);
          pin_stable[gi] <= (gi != 0);
        end else begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            pin_stable[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate
  assign pins = pin_stable;

  // edge detect on filtered clock, gated by select
  logic sclk_prev;
  logic sclk_rise;
  logic sclk_fall;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sclk_prev <= 1'b1;
    end else begin
      sclk_prev <= pins.sclk;
    end
  end
  assign sclk_rise = pins.sclk && !sclk_prev && !pins.cs_n;
  assign sclk_fall = !pins.sclk && sclk_prev && !pins.cs_n;

  ////////////////////////////////////////////////////////////////////////
  // frame decode: header {addr[4:0], read, 2'b00}, then data msb first
  logic [4:0] bit_count;
  logic [7:0] in_shift;
  logic [7:0] header;
  logic [23:0] out_shift;
  logic [7:0] next_in;
  logic hdr_done;
  logic wr_commit;
  logic [4:0] hdr_addr;
  logic hdr_read;
  assign next_in = {in_shift[6:0], pins.mosi};
  assign hdr_done = sclk_rise && bit_count == 5'd7;
  assign wr_commit = sclk_rise && bit_count == 5'd15 && !header[adc_regs_pkg::HDR_READ_BIT];
  assign hdr_addr = next_in[7:3];
  assign hdr_read = next_in[adc_regs_pkg::HDR_READ_BIT];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bit_count <= 5'd0;
      in_shift <= 8'h00;
      header <= 8'h00;
    end else if (pins.cs_n) begin
      bit_count <= 5'd0;
    end else if (sclk_rise) begin
      in_shift <= next_in;
      if (bit_count != 5'd31) begin
        bit_count <= bit_count + 5'd1;
      end
      if (bit_count == 5'd7) begin
        header <= next_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register state
  logic [23:0] current_sample;
  logic [23:0] voltage_one_sample;
  logic [23:0] voltage_two_sample;
  logic [15:0] sample_checksum;
  logic [15:0] settings_checksum;
  logic [15:0] align_count_capture;
  logic [7:0] setup_control;
  logic [7:0] emission_control;
  logic [11:0] align_count;
  logic [7:0] rsvd_rw_a;
  logic [7:0] rsvd_rw_b;
  logic protect;
  logic crc_changed;
  logic soft_rst;
  logic [31:0] start_count;
  logic [7:0] primary_flags;
  logic [7:0] secondary_flags;
  logic [7:0] temperature_offset;
  logic settings_wr_ok;

  // protection gates every settings write
  assign settings_wr_ok = wr_commit && !protect;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      current_sample <= 24'h000000;
      voltage_one_sample <= 24'h000000;
      voltage_two_sample <= 24'h000000;
      temperature_offset <= 8'h00;
    end else if (soft_rst) begin
      current_sample <= 24'h000000;
      voltage_one_sample <= 24'h000000;
      voltage_two_sample <= 24'h000000;
    end else if (sample_strobe) begin
      current_sample <= current_in;
      voltage_one_sample <= volt_one_in;
      voltage_two_sample <= volt_two_in;
      temperature_offset <= temp_offset_in;
    end
  end

  // crc-16 over a left-aligned bit string of the given length
  function automatic logic [15:0] crc16(input logic [71:0] data, input int nbits);
    logic [15:0] c;
    c = adc_regs_pkg::CRC_INIT;
    for (int i = 0; i < 72; i++) begin
      if (i < nbits) begin
        c = (c[15] ^ data[71 - i]) ? ({c[14:0], 1'b0} ^ adc_regs_pkg::CRC_POLY)
                                   : {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

  logic [15:0] next_settings_crc;
  assign next_settings_crc = crc16({setup_control, emission_control, 4'h0, align_count,
                                    40'h0000000000}, 32);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sample_checksum <= adc_regs_pkg::CRC_INIT;
      settings_checksum <= adc_regs_pkg::CRC_INIT;
    end else begin
      sample_checksum <= crc16({current_sample, voltage_one_sample, voltage_two_sample}, 72);
      settings_checksum <= next_settings_crc;
    end
  end

  // setup register, software reset bit becomes a one-cycle pulse
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      setup_control <= adc_regs_pkg::SETUP_RESET;
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= settings_wr_ok && header[7:3] == adc_regs_pkg::OFF_SETUP
                  && next_in[adc_regs_pkg::SETUP_SWRST_BIT];
      if (soft_rst) begin
        setup_control <= adc_regs_pkg::SETUP_RESET;
      end else if (settings_wr_ok && header[7:3] == adc_regs_pkg::OFF_SETUP) begin
        setup_control <= next_in & ~(8'h01 << adc_regs_pkg::SETUP_SWRST_BIT);
      end
    end
  end

  // reserved read-write locations accept writes but hold no function
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      emission_control <= adc_regs_pkg::EMISSION_RESET;
      rsvd_rw_a <= 8'h00;
      rsvd_rw_b <= 8'h00;
    end else if (soft_rst) begin
      emission_control <= adc_regs_pkg::EMISSION_RESET;
      rsvd_rw_a <= 8'h00;
      rsvd_rw_b <= 8'h00;
    end else if (settings_wr_ok) begin
      if (header[7:3] == adc_regs_pkg::OFF_EMISSION) begin
        emission_control <= next_in;
      end else if (header[7:3] == adc_regs_pkg::OFF_RSVD_RW_A) begin
        rsvd_rw_a <= next_in;
      end else if (header[7:3] == adc_regs_pkg::OFF_RSVD_RW_B) begin
        rsvd_rw_b <= next_in;
      end
    end
  end

  // free-running alignment counter, host may load either half
  // align command: 0x01 restarts count, 0x02 captures it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      align_count <= adc_regs_pkg::COUNT_RESET;
      align_count_capture <= adc_regs_pkg::CAPTURE_RESET;
    end else if (soft_rst) begin
      align_count <= adc_regs_pkg::COUNT_RESET;
      align_count_capture <= adc_regs_pkg::CAPTURE_RESET;
    end else if (settings_wr_ok && header[7:3] == adc_regs_pkg::OFF_COUNT_LOW) begin
      align_count <= {align_count[11:8], next_in};
    end else if (settings_wr_ok && header[7:3] == adc_regs_pkg::OFF_COUNT_HIGH) begin
      align_count <= {next_in[3:0], align_count[7:0]};
    end else if (settings_wr_ok && header[7:3] == adc_regs_pkg::OFF_ALIGN_CMD
                 && next_in == adc_regs_pkg::CMD_ALIGN) begin
      align_count <= adc_regs_pkg::COUNT_RESET;
    end else begin
      align_count <= align_count + 12'h001;
      if (settings_wr_ok && header[7:3] == adc_regs_pkg::OFF_ALIGN_CMD
          && next_in == adc_regs_pkg::CMD_CAPTURE) begin
        align_count_capture <= {4'h0, align_count};
      end
    end
  end

  // protection key; key writes pass even while protected
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      protect <= 1'b0;
    end else if (soft_rst) begin
      protect <= 1'b0;
    end else if (wr_commit && header[7:3] == adc_regs_pkg::OFF_KEY) begin
      if (next_in == adc_regs_pkg::KEY_PROTECT) begin
        protect <= 1'b1;
      end else if (next_in == adc_regs_pkg::KEY_UNPROTECT) begin
        protect <= 1'b0;
      end
    end
  end

  // busy until the startup count expires after any reset
  // checksum-change flag: change sets it, reading flags clears it, set wins
  logic rd_primary;
  assign rd_primary = hdr_done && hdr_read && hdr_addr == adc_regs_pkg::OFF_PRIMARY;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      start_count <= 32'd0;
      busy <= 1'b1;
      crc_changed <= 1'b0;
    end else begin
      if (soft_rst) begin
        start_count <= 32'd0;
        busy <= 1'b1;
      end else if (busy) begin
        start_count <= start_count + 32'd1;
        busy <= (start_count + 32'd1) < 32'(STARTUP);
      end
      if (!busy && next_settings_crc != settings_checksum) begin
        crc_changed <= 1'b1;
      end else if (rd_primary || soft_rst) begin
        crc_changed <= 1'b0;
      end
    end
  end

  always_comb begin
    primary_flags = 8'h00;
    primary_flags[adc_regs_pkg::PRIMARY_BUSY_BIT] = busy;
    primary_flags[adc_regs_pkg::PRIMARY_CRC_BIT] = crc_changed;
    primary_flags[adc_regs_pkg::PRIMARY_PROT_BIT] = protect;
    secondary_flags = {5'h00, VERSION};
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux, left aligned so the msb leaves first
  // reserved wide and reserved half, plus write-only keys, read zero
  logic [23:0] rd_value;
  always_comb begin
    if (hdr_addr == adc_regs_pkg::OFF_CURRENT) begin
      rd_value = current_sample;
    end else if (hdr_addr == adc_regs_pkg::OFF_VOLT_ONE) begin
      rd_value = voltage_one_sample;
    end else if (hdr_addr == adc_regs_pkg::OFF_VOLT_TWO) begin
      rd_value = voltage_two_sample;
    end else if (hdr_addr == adc_regs_pkg::OFF_SAMPLE_CRC) begin
      rd_value = {sample_checksum, 8'h00};
    end else if (hdr_addr == adc_regs_pkg::OFF_SETTINGS_CRC) begin
      rd_value = {settings_checksum, 8'h00};
    end else if (hdr_addr == adc_regs_pkg::OFF_CAPTURE) begin
      rd_value = {align_count_capture, 8'h00};
    end else if (hdr_addr == adc_regs_pkg::OFF_SETUP) begin
      rd_value = {setup_control, 16'h0000};
    end else if (hdr_addr == adc_regs_pkg::OFF_PRIMARY) begin
      rd_value = {primary_flags, 16'h0000};
    end else if (hdr_addr == adc_regs_pkg::OFF_COUNT_LOW) begin
      rd_value = {align_count[7:0], 16'h0000};
    end else if (hdr_addr == adc_regs_pkg::OFF_COUNT_HIGH) begin
      rd_value = {4'h0, align_count[11:8], 16'h0000};
    end else if (hdr_addr == adc_regs_pkg::OFF_EMISSION) begin
      rd_value = {emission_control, 16'h0000};
    end else if (hdr_addr == adc_regs_pkg::OFF_SECONDARY) begin
      rd_value = {secondary_flags, 16'h0000};
    end else if (hdr_addr == adc_regs_pkg::OFF_RSVD_RW_A) begin
      rd_value = {rsvd_rw_a, 16'h0000};
    end else if (hdr_addr == adc_regs_pkg::OFF_RSVD_RW_B) begin
      rd_value = {rsvd_rw_b, 16'h0000};
    end else if (hdr_addr == adc_regs_pkg::OFF_TEMP_OFFSET) begin
      rd_value = {temperature_offset, 16'h0000};
    end else begin
      rd_value = 24'h000000;
    end
  end

  // read-only offsets have no write path above; shifter only reads
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      out_shift <= 24'h000000;
    end else if (hdr_done) begin
      out_shift <= hdr_read ? rd_value : 24'h000000;
    end else if (sclk_fall && bit_count > 5'd8) begin
      out_shift <= {out_shift[22:0], 1'b0};
    end
  end

  // outputs from flip-flops; miso driven only inside a frame
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      miso <= 1'b0;
      miso_oe <= 1'b0;
      setup_out <= '0;
      emission_out <= adc_regs_pkg::EMISSION_RESET;
    end else begin
      miso <= out_shift[23];
      miso_oe <= !pins.cs_n;
      setup_out <= {setup_control[7], setup_control[5:2], setup_control[0]};
      emission_out <= emission_control;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_reserved_wide_zero: assert property (@(posedge mclk) disable iff (!resetn)
    hdr_done && hdr_read && hdr_addr == adc_regs_pkg::OFF_RSVD_WIDE |=> out_shift == 24'h000000)
    else $error("reserved wide location read nonzero");
  a_reserved_half_zero: assert property (@(posedge mclk) disable iff (!resetn)
    hdr_done && hdr_read && hdr_addr == adc_regs_pkg::OFF_RSVD_HALF |=> out_shift == 24'h000000)
    else $error("reserved half location read nonzero");
  a_key_reads_zero: assert property (@(posedge mclk) disable iff (!resetn)
    hdr_done && hdr_read && hdr_addr == adc_regs_pkg::OFF_KEY |=> out_shift == 24'h000000)
    else $error("protection key read nonzero");
  a_lock_sets_protect: assert property (@(posedge mclk) disable iff (!resetn)
    wr_commit && header[7:3] == adc_regs_pkg::OFF_KEY && next_in == adc_regs_pkg::KEY_PROTECT
    |=> protect ##1 primary_flags[adc_regs_pkg::PRIMARY_PROT_BIT])
    else $error("protect key did not lock");
  a_protected_setup_held: assert property (@(posedge mclk) disable iff (!resetn)
    protect && wr_commit && header[7:3] == adc_regs_pkg::OFF_SETUP |=> $stable(setup_control))
    else $error("setup changed while protected");
  a_capture_copy: assert property (@(posedge mclk) disable iff (!resetn)
    settings_wr_ok && header[7:3] == adc_regs_pkg::OFF_ALIGN_CMD
    && next_in == adc_regs_pkg::CMD_CAPTURE |=> align_count_capture == {4'h0, $past(align_count)})
    else $error("capture did not copy counter");
  a_readonly_kept: assert property (@(posedge mclk) disable iff (!resetn)
    wr_commit && header[7:3] == adc_regs_pkg::OFF_CAPTURE |=> $stable(align_count_capture))
    else $error("read-only capture changed on write");
  a_soft_reset_busy: assert property (@(posedge mclk) disable iff (!resetn)
    soft_rst |=> busy && setup_control == adc_regs_pkg::SETUP_RESET
    && emission_control == adc_regs_pkg::EMISSION_RESET)
    else $error("software reset did not restore defaults");
  a_version_read: assert property (@(posedge mclk) disable iff (!resetn)
    hdr_done && hdr_read && hdr_addr == adc_regs_pkg::OFF_SECONDARY
    |=> out_shift[18:16] == VERSION && out_shift[23:19] == 5'h00)
    else $error("version field wrong");

endmodule
`default_nettype wire

// >>> rtl/adc_regs_pkg.sv
package adc_regs_pkg;

  // register offsets
  localparam logic [4:0] OFF_CURRENT = 5'h00;
  localparam logic [4:0] OFF_VOLT_ONE = 5'h01;
  localparam logic [4:0] OFF_VOLT_TWO = 5'h02;
  localparam logic [4:0] OFF_RSVD_WIDE = 5'h03;
  localparam logic [4:0] OFF_SAMPLE_CRC = 5'h04;
  localparam logic [4:0] OFF_SETTINGS_CRC = 5'h05;
  localparam logic [4:0] OFF_RSVD_HALF = 5'h06;
  localparam logic [4:0] OFF_CAPTURE = 5'h07;
  localparam logic [4:0] OFF_SETUP = 5'h08;
  localparam logic [4:0] OFF_PRIMARY = 5'h09;
  localparam logic [4:0] OFF_KEY = 5'h0a;
  localparam logic [4:0] OFF_ALIGN_CMD = 5'h0b;
  localparam logic [4:0] OFF_COUNT_LOW = 5'h0c;
  localparam logic [4:0] OFF_COUNT_HIGH = 5'h0d;
  localparam logic [4:0] OFF_EMISSION = 5'h0e;
  localparam logic [4:0] OFF_SECONDARY = 5'h0f;
  localparam logic [4:0] OFF_RSVD_RW_A = 5'h10;
  localparam logic [4:0] OFF_RSVD_RW_B = 5'h11;
  localparam logic [4:0] OFF_TEMP_OFFSET = 5'h18;

  // reset values
  localparam logic [7:0] SETUP_RESET = 8'h00;
  localparam logic [7:0] PRIMARY_RESET = 8'h01;
  localparam logic [7:0] EMISSION_RESET = 8'hff;
  localparam logic [11:0] COUNT_RESET = 12'h000;
  localparam logic [15:0] CAPTURE_RESET = 16'h0000;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;

  // keys and commands
  localparam logic [7:0] KEY_PROTECT = 8'hca;
  localparam logic [7:0] KEY_UNPROTECT = 8'h9c;
  localparam logic [7:0] CMD_ALIGN = 8'h01;
  localparam logic [7:0] CMD_CAPTURE = 8'h02;

  // field positions
  localparam int SETUP_SWRST_BIT = 6;
  localparam int PRIMARY_BUSY_BIT = 0;
  localparam int PRIMARY_CRC_BIT = 1;
  localparam int PRIMARY_PROT_BIT = 2;
  localparam int HDR_READ_BIT = 2;

  // timing: readiness after reset
  localparam int STARTUP_MS = 20;
  localparam int CLOCK_HZ = 25000000;
  localparam int STARTUP_CYCLES = STARTUP_MS * (CLOCK_HZ / 1000);

  // serial pins grouped after synchronising
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } serial_pins_t;

  // setup fields driven to the converter
  typedef struct packed {
    logic bandwidth_low;
    logic [1:0] rate_sel;
    logic temp_sel;
    logic power_down;
    logic clock_out_en;
  } setup_out_t;

endpackage

// >>> verification/spi_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  // clock
  input wire logic mclk,
  // serial port pins
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  localparam int HALF = 8; // mclk per sclk half, kept above the 6 minimum
  logic [23:0] shift_in;
  // idle: clock stands high, select off
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b1;
    shift_in = 24'h000000;
  end
  ////////////////////////////////////////////////////////////////////////
  // one bit: drive on the fall, sample at the rise, msb first
  task automatic bit_cycle(input logic b);
    @(negedge mclk);
    sclk = 1'b0;
    mosi = b;
    repeat (HALF) @(negedge mclk);
    sclk = 1'b1;
    shift_in = {shift_in[22:0], miso};
    repeat (HALF - 1) @(negedge mclk);
  endtask
  // whole frame; released data line shows the inverse of its last value
  task automatic frame(input logic [4:0] addr, input logic rd, input logic [7:0] wdata,
                       input int nbits, output logic [23:0] rdata);
    logic [7:0] hdr;
    hdr = {addr, rd, 2'b00};
    @(negedge mclk);
    cs_n = 1'b0;
    repeat (HALF) @(negedge mclk);
    for (int i = 7; i >= 0; i--) bit_cycle(hdr[i]);
    if (rd) begin
      for (int i = 0; i < nbits; i++) bit_cycle(i[0]);
    end else begin
      for (int i = 7; i >= 0; i--) bit_cycle(wdata[i]);
    end
    repeat (HALF) @(negedge mclk);
    cs_n = 1'b1;
    mosi = ~mosi;
    repeat (HALF) @(negedge mclk);
    rdata = 24'(32'(shift_in) & ((32'h1 << nbits) - 32'h1));
  endtask
  ////////////////////////////////////////////////////////////////////////
  // one-byte writes, reserved pair skipped
  task automatic write(input logic [4:0] addr, input logic [7:0] data);
    logic [23:0] unused;
    if (addr != 5'h10 && addr != 5'h11) begin
      frame(addr, 1'b0, data, 8, unused);
    end
  endtask
  task automatic read(input logic [4:0] addr, input int nbits, output logic [23:0] val);
    frame(addr, 1'b1, 8'h00, nbits, val);
  endtask
endmodule
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic mclk;
  logic resetn;
  logic sclk, cs_n, mosi, miso, miso_oe;
  logic [23:0] current_in, volt_one_in, volt_two_in;
  logic sample_strobe;
  logic [7:0] temp_offset_in;
  adc_regs_pkg::setup_out_t setup_out;
  logic [7:0] emission_out;
  logic busy;
  logic [23:0] rd;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int mark;
  logic found;
  localparam int LIMIT = 40000; // about three times the expected run
  // packed tables, index 0 leftmost
  localparam logic [0:7][4:0] DEF_A = {5'h03, 5'h06, 5'h07, 5'h08, 5'h0a, 5'h0b, 5'h0e, 5'h10};
  localparam logic [0:7][4:0] DEF_N = {5'h18, 5'h10, 5'h10, 5'h08, 5'h08, 5'h08, 5'h08, 5'h08};
  localparam logic [0:7][23:0] DEF_V = {24'h000000, 24'h000000, 24'h000000, 24'h000000,
                                        24'h000000, 24'h000000, 24'h0000ff, 24'h000000};

  // short startup so readiness is seen within the run
  adc_regs #(.STARTUP(400), .VERSION(3'h5)) u_adc_regs (
    .mclk(mclk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .current_in(current_in),
    .volt_one_in(volt_one_in), .volt_two_in(volt_two_in),
    .sample_strobe(sample_strobe), .temp_offset_in(temp_offset_in),
    .setup_out(setup_out), .emission_out(emission_out), .busy(busy));
  spi_host_model u_spi_host_model (
    .mclk(mclk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  ////////////////////////////////////////////////////////////////////////
  // clock, and the hang guard
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      num_errors++;
      test_done();
    end
  end

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [4:0] a, input int n, input logic [23:0] exp);
    u_spi_host_model.read(a, n, rd);
    check($sformatf("reg %h", a), rd, exp);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    u_spi_host_model.write(a, d);
  endtask
  // bitwise crc, msb first, independent of the design's own code
  function automatic logic [15:0] crc16(input logic [71:0] d, input int nbits);
    logic [15:0] c;
    c = adc_regs_pkg::CRC_INIT;
    for (int i = 71; i >= 72 - nbits; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? adc_regs_pkg::CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
  task automatic test_done();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    resetn = 1'b0;
    current_in = 24'h000000;
    volt_one_in = 24'h000000;
    volt_two_in = 24'h000000;
    sample_strobe = 1'b0;
    temp_offset_in = 8'h00;
    repeat (10) @(negedge mclk);
    check("busy in reset", 24'(busy), 24'h1);
    check("emission in reset", 24'(emission_out), 24'hff);
    check("setup_out in reset", 24'(setup_out), 24'h0);
    check("miso_oe idle", 24'(miso_oe), 24'h0);
    resetn = 1'b1;
    repeat (8) @(negedge mclk);
    check("busy after release", 24'(busy), 24'h1);
    rd_chk(adc_regs_pkg::OFF_PRIMARY, 8, 24'h01);
    // readiness must come within the startup count
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge mclk);
    check("busy ends", 24'(busy), 24'h0);
    for (int i = 0; i < 8; i++) rd_chk(DEF_A[i], DEF_N[i], DEF_V[i]);
    u_spi_host_model.read(adc_regs_pkg::OFF_SECONDARY, 8, rd);
    check("version", 24'(rd[2:0]), 24'h5);
    // samples latched by the strobe, current input moved after it
    current_in = 24'h800001;
    volt_one_in = 24'hfffffe;
    volt_two_in = 24'h7fffff;
    temp_offset_in = 8'h9c;
    sample_strobe = 1'b1;
    @(negedge mclk);
    sample_strobe = 1'b0;
    current_in = 24'h123456;
    rd_chk(adc_regs_pkg::OFF_CURRENT, 24, 24'h800001);
    rd_chk(adc_regs_pkg::OFF_VOLT_ONE, 24, 24'hfffffe);
    rd_chk(adc_regs_pkg::OFF_VOLT_TWO, 24, 24'h7fffff);
    rd_chk(adc_regs_pkg::OFF_TEMP_OFFSET, 8, 24'h9c);
    rd_chk(adc_regs_pkg::OFF_SAMPLE_CRC, 16, 24'(crc16(72'h800001fffffe7fffff, 72)));
    wr(adc_regs_pkg::OFF_CURRENT, 8'h55);
    wr(adc_regs_pkg::OFF_TEMP_OFFSET, 8'h11);
    rd_chk(adc_regs_pkg::OFF_CURRENT, 24, 24'h800001);
    rd_chk(adc_regs_pkg::OFF_TEMP_OFFSET, 8, 24'h9c);
    // settings reach the converter side
    wr(adc_regs_pkg::OFF_SETUP, 8'hb9);
    wr(adc_regs_pkg::OFF_EMISSION, 8'h5a);
    check("setup_out", 24'(setup_out), 24'h3d);
    check("emission_out", 24'(emission_out), 24'h5a);
    rd_chk(adc_regs_pkg::OFF_SETUP, 8, 24'hb9);
    // protection refuses settings writes until unlocked
    wr(adc_regs_pkg::OFF_KEY, adc_regs_pkg::KEY_PROTECT);
    rd_chk(adc_regs_pkg::OFF_KEY, 8, 24'h00);
    u_spi_host_model.read(adc_regs_pkg::OFF_PRIMARY, 8, rd);
    check("protected flag", 24'(rd[2]), 24'h1);
    wr(adc_regs_pkg::OFF_SETUP, 8'h00);
    wr(adc_regs_pkg::OFF_EMISSION, 8'h11);
    rd_chk(adc_regs_pkg::OFF_SETUP, 8, 24'hb9);
    check("emission locked", 24'(emission_out), 24'h5a);
    wr(adc_regs_pkg::OFF_KEY, adc_regs_pkg::KEY_UNPROTECT);
    u_spi_host_model.read(adc_regs_pkg::OFF_PRIMARY, 8, rd);
    check("unprotected flag", 24'(rd[2]), 24'h0);
    wr(adc_regs_pkg::OFF_EMISSION, 8'h11);
    check("emission unlocked", 24'(emission_out), 24'h11);
    // capture holds the cycles between zeroing and snapshot
    wr(adc_regs_pkg::OFF_ALIGN_CMD, adc_regs_pkg::CMD_ALIGN);
    mark = cycles;
    // settings crc covers setup, emission and the young counter
    u_spi_host_model.read(adc_regs_pkg::OFF_SETTINGS_CRC, 16, rd);
    found = 1'b0;
    for (int k = 0; k < 512; k++) begin
      if (rd[15:0] == crc16({8'hb9, 8'h11, 16'(k), 40'h0000000000}, 32)) found = 1'b1;
    end
    check("settings crc", 24'(found), 24'h1);
    wr(adc_regs_pkg::OFF_ALIGN_CMD, adc_regs_pkg::CMD_CAPTURE);
    mark = cycles - mark;
    u_spi_host_model.read(adc_regs_pkg::OFF_CAPTURE, 16, rd);
    check("capture window", 24'(rd >= mark - 2 && rd <= mark + 2), 24'h1);
    wr(adc_regs_pkg::OFF_CAPTURE, 8'h33);
    rd_chk(adc_regs_pkg::OFF_CAPTURE, 16, rd);
    wr(adc_regs_pkg::OFF_COUNT_LOW, 8'h00);
    wr(adc_regs_pkg::OFF_COUNT_HIGH, 8'h07);
    rd_chk(adc_regs_pkg::OFF_COUNT_HIGH, 8, 24'h07);
    // software reset restores defaults and restarts readiness
    wr(adc_regs_pkg::OFF_SETUP, 8'h40);
    check("busy after soft reset", 24'(busy), 24'h1);
    check("emission after soft reset", 24'(emission_out), 24'hff);
    rd_chk(adc_regs_pkg::OFF_SETUP, 8, 24'h00);
    test_done();
  end
endmodule
`default_nettype wire
